// *** rtl/one_wire_debug_consts.svh ***
// constants shared by both ends of the one-wire debug link
`ifndef ONE_WIRE_DEBUG_CONSTS_SVH
`define ONE_WIRE_DEBUG_CONSTS_SVH

// ****************************************
// clock and timing
// ****************************************
`define CLK_MHZ              25
`define ENABLE_LOW_MIN_NS    200
`define ENABLE_LOW_CYCLES    ((`ENABLE_LOW_MIN_NS * `CLK_MHZ) / 1000 + 1)
`define SYNC_TIMEOUT_CYCLES  65536
`define GPIO_GUARD_MIN_US    8800
`define GPIO_GUARD_CYCLES    (`GPIO_GUARD_MIN_US * `CLK_MHZ)
`define HV_HOLD_MIN_US       100
`define HV_HOLD_CYCLES       (`HV_HOLD_MIN_US * `CLK_MHZ)
`define HOST_BIT_CYCLES      16'h0032

// ****************************************
// characters, frame, fuse and keys
// ****************************************
`define SYNC_CHAR            8'h55
`define SYNC_FALL_LAST       3'h4
`define SYNC_MIN_COUNT       17'h00010
`define FRAME_BITS           4'hC
`define FUSE_PIN_DEBUG       1'h1
`define FUSE_PIN_GPIO        1'h0
`define KEY_PROGRAM          8'hA5
`define KEY_ERASE_ALL        8'h5A

`endif

// *** rtl/one_wire_debug_pkg.sv ***
// types shared by both ends of the one-wire debug link
package one_wire_debug_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_HV_RESET,
    ST_HOLD,
    ST_WAIT_SYNC,
    ST_MEASURE,
    ST_ENABLED
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_HV,
    H_LOW,
    H_POLL,
    H_READY,
    H_TX
  } host_state_t;

endpackage : one_wire_debug_pkg

// *** rtl/one_wire_if.sv ***
// open-drain one-wire link between programmer and debug port
`timescale 1ns/100ps
interface one_wire_if;
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;
  logic hv_pulse;
  logic disable_store;
  logic line;

  // pull-up wins unless an enabled driver pulls low
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

  modport device (
    input  line,
    input  hv_pulse,
    input  disable_store,
    output dev_out,
    output dev_oe
  );

  modport host (
    input  line,
    output host_out,
    output host_oe,
    output hv_pulse,
    output disable_store
  );
endinterface : one_wire_if

// *** rtl/one_wire_debug_port.sv ***
// device end: enable, sync baud detection and start-up self-disable
`timescale 1ns/100ps
`include "one_wire_debug_consts.svh"
module one_wire_debug_port
  import one_wire_debug_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT = `SYNC_TIMEOUT_CYCLES,
  parameter int unsigned GPIO_GUARD   = `GPIO_GUARD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  one_wire_if.device       link,
  input  wire logic        osc_ready_i,
  input  wire logic        reset_pin_function_fuse_i,
  input  wire logic        sys_reset_i,
  input  wire logic        key_strobe_i,
  input  wire logic [7:0]  key_i,
  input  wire logic        locked_i,
  output logic             osc_req_o,
  output logic             enabled_o,
  output logic             pin_debug_mode_o,
  output logic             gpio_oe_allow_o,
  output logic [15:0]      baud_count_o,
  output logic             prog_enable_o,
  output logic             erase_req_o
);
  import one_wire_debug_pkg::*;

  // ****************************************
  // state
  // ****************************************
  dev_state_t  state_q,      state_d;
  logic [16:0] cnt_q,        cnt_d;
  logic [2:0]  falls_q,      falls_d;
  logic [15:0] baud_q,       baud_d;
  logic        hv_mode_q,    hv_mode_d;
  logic        drive_q,      drive_d;
  logic        osc_req_q,    osc_req_d;
  logic        enabled_q,    enabled_d;
  logic        prog_q,       prog_d;
  logic        erase_q,      erase_d;
  logic        pin_mode_q,   pin_mode_d;
  logic [17:0] guard_q,      guard_d;
  logic        gpio_ok_q,    gpio_ok_d;
  logic        pin_out_q;
  logic        line_s1_q,    line_s2_q,  line_prev_q;
  logic        hv_s1_q,      hv_s2_q,    hv_prev_q;
  logic        osc_s1_q,     osc_s2_q;
  logic        fall;
  logic        hv_rise;

  assign fall    = line_prev_q & ~line_s2_q;
  assign hv_rise = hv_s2_q & ~hv_prev_q;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    falls_d   = falls_q;
    baud_d    = baud_q;
    hv_mode_d = hv_mode_q;
    prog_d    = prog_q;
    erase_d   = 1'b0;
    guard_d   = guard_q;
    if (hv_rise) begin
      state_d   = ST_HV_RESET;
      hv_mode_d = 1'b1;
    end else begin
      case (state_q)
        ST_OFF: begin
          // pin must belong to the port before an edge may wake it
          if (fall && (reset_pin_function_fuse_i == `FUSE_PIN_DEBUG || hv_mode_q)) begin
            state_d = ST_HOLD;
          end
        end
        ST_HV_RESET: begin
          if (fall) begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (osc_s2_q) begin
            state_d = ST_WAIT_SYNC;
            cnt_d   = 17'h00000;
          end
        end
        ST_WAIT_SYNC: begin
          if (fall) begin
            state_d = ST_MEASURE;
            cnt_d   = 17'h00000;
            falls_d = 3'h0;
          end else if (cnt_q == 17'(SYNC_TIMEOUT - 1)) begin
            state_d = ST_OFF;
          end else begin
            cnt_d = cnt_q + 17'h00001;
          end
        end
        ST_MEASURE: begin
          // falls of 0x55 sit at bit 0, 2, 4, 6 and 8: first to last spans 8 bits
          cnt_d = cnt_q + 17'h00001;
          if (cnt_q[16]) begin
            state_d = ST_OFF;
          end else if (fall) begin
            falls_d = falls_q + 3'h1;
            if (falls_q == `SYNC_FALL_LAST - 3'h1) begin
              // a span of 65536 would wrap the 16-bit count to zero
              if (cnt_q + 17'h00001 < `SYNC_MIN_COUNT || cnt_q[15:0] == 16'hFFFF) begin
                state_d = ST_OFF;
              end else begin
                baud_d  = cnt_q[15:0] + 16'h0001;
                state_d = ST_ENABLED;
              end
            end
          end
        end
        ST_ENABLED: begin
          if (link.disable_store) begin
            state_d = ST_OFF;
          end
        end
        default: begin
          state_d = ST_OFF;
        end
      endcase
    end
    if (state_d != ST_ENABLED) begin
      prog_d = 1'b0;
    end else if (key_strobe_i && state_q == ST_ENABLED) begin
      // a locked part ignores the programming key, erase is always honoured
      if (key_i == `KEY_PROGRAM && !locked_i) begin
        prog_d = 1'b1;
      end
      erase_d = (key_i == `KEY_ERASE_ALL);
    end
    if (sys_reset_i) begin
      guard_d = 18'(GPIO_GUARD);
    end else if (guard_q != 18'h00000) begin
      guard_d = guard_q - 18'h00001;
    end
    drive_d    = (state_d == ST_HOLD);
    osc_req_d  = (state_d == ST_HOLD) || (state_d == ST_WAIT_SYNC) ||
                 (state_d == ST_MEASURE) || (state_d == ST_ENABLED);
    enabled_d  = (state_d == ST_ENABLED);
    pin_mode_d = hv_mode_d || (reset_pin_function_fuse_i == `FUSE_PIN_DEBUG);
    gpio_ok_d  = !pin_mode_d && (guard_d == 18'h00000);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_OFF;
      cnt_q       <= 17'h00000;
      falls_q     <= 3'h0;
      baud_q      <= 16'h0000;
      hv_mode_q   <= 1'b0;
      drive_q     <= 1'b0;
      osc_req_q   <= 1'b0;
      enabled_q   <= 1'b0;
      prog_q      <= 1'b0;
      erase_q     <= 1'b0;
      pin_mode_q  <= 1'b0;
      guard_q     <= 18'(GPIO_GUARD);
      gpio_ok_q   <= 1'b0;
      pin_out_q   <= 1'b0;
      line_s1_q   <= 1'b1;
      line_s2_q   <= 1'b1;
      line_prev_q <= 1'b1;
      hv_s1_q     <= 1'b0;
      hv_s2_q     <= 1'b0;
      hv_prev_q   <= 1'b0;
      osc_s1_q    <= 1'b0;
      osc_s2_q    <= 1'b0;
    end else if (ce_i) begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      falls_q     <= falls_d;
      baud_q      <= baud_d;
      hv_mode_q   <= hv_mode_d;
      drive_q     <= drive_d;
      osc_req_q   <= osc_req_d;
      enabled_q   <= enabled_d;
      prog_q      <= prog_d;
      erase_q     <= erase_d;
      pin_mode_q  <= pin_mode_d;
      guard_q     <= guard_d;
      gpio_ok_q   <= gpio_ok_d;
      pin_out_q   <= 1'b0;
      line_s1_q   <= link.line;
      line_s2_q   <= line_s1_q;
      line_prev_q <= line_s2_q;
      hv_s1_q     <= link.hv_pulse;
      hv_s2_q     <= hv_s1_q;
      hv_prev_q   <= hv_s2_q;
      osc_s1_q    <= osc_ready_i;
      osc_s2_q    <= osc_s1_q;
    end
  end

  assign link.dev_out     = pin_out_q;
  assign link.dev_oe      = drive_q;
  assign osc_req_o        = osc_req_q;
  assign enabled_o        = enabled_q;
  assign pin_debug_mode_o = pin_mode_q;
  assign gpio_oe_allow_o  = gpio_ok_q;
  assign baud_count_o     = baud_q;
  assign prog_enable_o    = prog_q;
  assign erase_req_o      = erase_q;

endmodule : one_wire_debug_port

// *** rtl/one_wire_host.sv ***
// programmer end: enable pulse, high-voltage entry and framed transmit
`timescale 1ns/100ps
`include "one_wire_debug_consts.svh"
module one_wire_host
  import one_wire_debug_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  one_wire_if.host         link,
  input  wire logic        enable_i,
  input  wire logic        hv_enable_i,
  input  wire logic        send_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        no_sync_next_i,
  input  wire logic        finish_i,
  output logic             busy_o,
  output logic             ready_o
);
  import one_wire_debug_pkg::*;

  // ****************************************
  // state
  // ****************************************
  host_state_t state_q,   state_d;
  logic [15:0] tick_q,    tick_d;
  logic [3:0]  bit_q,     bit_d;
  logic [11:0] frame_q,   frame_d;
  logic [7:0]  pend_q,    pend_d;
  logic        pend_v_q,  pend_v_d;
  logic        need_q,    need_d;
  logic        nxt_need_q, nxt_need_d;
  logic        oe_q,      oe_d;
  logic        hv_q,      hv_d;
  logic        dis_q,     dis_d;
  logic        busy_q,    busy_d;
  logic        ready_q,   ready_d;
  logic        out_q;
  logic        line_s1_q, line_s2_q;

  // start low, data lsb first, even parity, two high stops
  function automatic logic [11:0] make_frame(input logic [7:0] b);
    make_frame = {2'b11, ^b, b, 1'b0};
  endfunction : make_frame

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    state_d    = state_q;
    tick_d     = tick_q;
    bit_d      = bit_q;
    frame_d    = frame_q;
    pend_d     = pend_q;
    pend_v_d   = pend_v_q;
    need_d     = need_q;
    nxt_need_d = nxt_need_q;
    hv_d       = 1'b0;
    dis_d      = 1'b0;
    case (state_q)
      H_IDLE: begin
        if (hv_enable_i) begin
          state_d = H_HV;
          tick_d  = 16'h0000;
        end else if (enable_i) begin
          state_d = H_LOW;
          tick_d  = 16'h0000;
        end
      end
      H_HV: begin
        // target reset is released before this point by the caller
        hv_d   = 1'b1;
        tick_d = tick_q + 16'h0001;
        // the level register lags the state by one cycle, so count one tick more
        if (tick_q == 16'(`HV_HOLD_CYCLES)) begin
          hv_d    = 1'b0;
          state_d = H_LOW;
          tick_d  = 16'h0000;
        end
      end
      H_LOW: begin
        tick_d = tick_q + 16'h0001;
        if (tick_q == 16'(`ENABLE_LOW_CYCLES - 1)) begin
          state_d = H_POLL;
          tick_d  = 16'h0000;
        end
      end
      H_POLL: begin
        // skip the first samples: the synchroniser still shows our own low
        if (tick_q < 16'h0004) begin
          tick_d = tick_q + 16'h0001;
        end else if (line_s2_q) begin
          state_d  = H_TX;
          frame_d  = make_frame(`SYNC_CHAR);
          pend_v_d = 1'b0;
          need_d   = 1'b0;
          tick_d   = 16'h0000;
          bit_d    = 4'h0;
        end
      end
      H_READY: begin
        if (finish_i) begin
          dis_d   = 1'b1;
          state_d = H_IDLE;
        end else if (send_i) begin
          state_d    = H_TX;
          tick_d     = 16'h0000;
          bit_d      = 4'h0;
          nxt_need_d = !no_sync_next_i;
          if (need_q) begin
            frame_d  = make_frame(`SYNC_CHAR);
            pend_d   = data_i;
            pend_v_d = 1'b1;
          end else begin
            frame_d  = make_frame(data_i);
            pend_v_d = 1'b0;
            need_d   = !no_sync_next_i;
          end
        end
      end
      H_TX: begin
        tick_d = tick_q + 16'h0001;
        if (tick_q == `HOST_BIT_CYCLES - 16'h0001) begin
          tick_d  = 16'h0000;
          bit_d   = bit_q + 4'h1;
          frame_d = {1'b1, frame_q[11:1]};
          if (bit_q == `FRAME_BITS - 4'h1) begin
            bit_d = 4'h0;
            if (pend_v_q) begin
              frame_d  = make_frame(pend_q);
              pend_v_d = 1'b0;
              need_d   = nxt_need_q;
            end else begin
              state_d = H_READY;
            end
          end
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
    oe_d    = (state_d == H_LOW) || (state_d == H_TX && !frame_d[0]);
    busy_d  = (state_d != H_IDLE) && (state_d != H_READY);
    ready_d = (state_d == H_READY);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q    <= H_IDLE;
      tick_q     <= 16'h0000;
      bit_q      <= 4'h0;
      frame_q    <= 12'hFFF;
      pend_q     <= 8'h00;
      pend_v_q   <= 1'b0;
      need_q     <= 1'b1;
      nxt_need_q <= 1'b1;
      oe_q       <= 1'b0;
      hv_q       <= 1'b0;
      dis_q      <= 1'b0;
      busy_q     <= 1'b0;
      ready_q    <= 1'b0;
      out_q      <= 1'b0;
      line_s1_q  <= 1'b1;
      line_s2_q  <= 1'b1;
    end else if (ce_i) begin
      state_q    <= state_d;
      tick_q     <= tick_d;
      bit_q      <= bit_d;
      frame_q    <= frame_d;
      pend_q     <= pend_d;
      pend_v_q   <= pend_v_d;
      need_q     <= need_d;
      nxt_need_q <= nxt_need_d;
      oe_q       <= oe_d;
      hv_q       <= hv_d;
      dis_q      <= dis_d;
      busy_q     <= busy_d;
      ready_q    <= ready_d;
      out_q      <= 1'b0;
      line_s1_q  <= link.line;
      line_s2_q  <= line_s1_q;
    end
  end

  assign link.host_out      = out_q;
  assign link.host_oe       = oe_q;
  assign link.hv_pulse      = hv_q;
  assign link.disable_store = dis_q;
  assign busy_o             = busy_q;
  assign ready_o            = ready_q;

endmodule : one_wire_host

// *** testbench/one_wire_chk.sv ***
// concurrent checks on the one-wire link and the port state
`timescale 1ns/100ps
`include "one_wire_debug_consts.svh"
module one_wire_chk #(
  parameter int unsigned SYNC_TIMEOUT = 65536
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        dev_out_i,
  input  wire logic        dev_oe_i,
  input  wire logic        host_out_i,
  input  wire logic        host_oe_i,
  input  wire logic        hv_pulse_i,
  input  wire logic        disable_store_i,
  input  wire logic        line_i,
  input  wire logic        osc_req_i,
  input  wire logic        enabled_i,
  input  wire logic        pin_debug_mode_i,
  input  wire logic [15:0] baud_count_i
);
  // ****************************************
  // idle time after release, length of the high-voltage pulse
  // ****************************************
  int unsigned idle_q;
  int unsigned idle_d;
  int unsigned hv_len_q;
  int unsigned hv_len_d;

  always_comb begin
    idle_d   = 0;
    hv_len_d = 0;
    if (osc_req_i && !enabled_i && !dev_oe_i && line_i) begin
      idle_d = idle_q + 1;
    end
    if (hv_pulse_i) begin
      hv_len_d = hv_len_q + 1;
    end
  end

  always_ff @(posedge clk_i) begin
    idle_q   <= rst_n_i ? idle_d : 0;
    hv_len_q <= rst_n_i ? hv_len_d : 0;
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  open_drain_a: assert property (!dev_out_i && !host_out_i)
    else $error("link driver drove the line high");
  low_pulse_a: assert property ($rose(host_oe_i) |-> host_oe_i [*6])
    else $error("host low pulse too short");
  hold_low_a: assert property (
    $rose(dev_oe_i) |-> osc_req_i && pin_debug_mode_i && !$past(line_i))
    else $error("port drove pin without a falling edge");
  wait_high_a: assert property ($rose(host_oe_i) |-> !dev_oe_i)
    else $error("host drove while port held the pin");
  release_gap_a: assert property ($fell(host_oe_i) |-> !host_oe_i [*4])
    else $error("host drove again too soon");
  fall_wake_a: assert property (
    $fell(line_i) && pin_debug_mode_i && !osc_req_i |-> ##[2:5] dev_oe_i)
    else $error("falling edge did not wake the port");
  stop_clean_a: assert property (
    disable_store_i && enabled_i |-> ##[1:2] (!enabled_i && !osc_req_i))
    else $error("disable store did not stop the port");
  hv_keep_a: assert property (!$fell(pin_debug_mode_i))
    else $error("pin debug mode dropped without reset");
  baud_eight_a: assert property (
    $rose(enabled_i) |-> baud_count_i == (`HOST_BIT_CYCLES << 3))
    else $error("baud count is not eight bit times");
  sync_timeout_a: assert property (idle_q < SYNC_TIMEOUT + 8)
    else $error("port stayed awake without sync");
  hv_reset_a: assert property (
    $rose(hv_pulse_i) |-> ##[1:5] (!osc_req_i && !enabled_i))
    else $error("high-voltage edge did not reset the port");
  // the hold window runs from one to ten minimum hold times
  hv_hold_a: assert property (
    $fell(hv_pulse_i) |-> hv_len_q >= `HV_HOLD_CYCLES && hv_len_q <= 10 * `HV_HOLD_CYCLES)
    else $error("high-voltage pulse length out of range");

  enable_c: cover property ($rose(enabled_i));
  timeout_c: cover property ($fell(osc_req_i) && !enabled_i);
  stop_c: cover property (disable_store_i && enabled_i);
  hv_c: cover property ($rose(hv_pulse_i));
endmodule : one_wire_chk

// *** testbench/tb_top.sv ***
// self-checking bench joining the programmer end to the debug port end
`timescale 1ns/100ps
`include "one_wire_debug_consts.svh"
module tb_top;
  localparam int TMO = 200;
  localparam int BIT = `HOST_BIT_CYCLES;
  logic       clk = 1'b0, rst_n = 1'b0, host_ce = 1'b1, osc_ready = 1'b0, fuse = 1'b0;
  logic       sys_reset = 1'b0, key_strobe = 1'b0, locked = 1'b0, enable = 1'b0;
  logic       hv_enable = 1'b0, send = 1'b0, no_sync = 1'b0, finish = 1'b0;
  logic [7:0] key = 8'h00, data = 8'h00;
  logic       osc_req, enabled, pin_mode, gpio_allow, prog_en, erase_req, busy, ready;
  logic [15:0] baud;
  logic [7:0] kt [3] = '{`KEY_PROGRAM, `KEY_ERASE_ALL, `KEY_PROGRAM};
  logic [7:0] dt [3] = '{8'hC3, 8'h3C, 8'h0F};
  logic [7:0] gb [3] = '{8'hC3, 8'h3C, `SYNC_CHAR};
  int         osc_cnt = 0, check_count = 0, bad_count = 0, n;

  one_wire_if link ();
  wire        line = link.line;
  one_wire_debug_port #(.SYNC_TIMEOUT(TMO), .GPIO_GUARD(100)) one_wire_debug_port_inst (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .link(link), .osc_ready_i(osc_ready),
    .reset_pin_function_fuse_i(fuse), .sys_reset_i(sys_reset), .key_strobe_i(key_strobe),
    .key_i(key), .locked_i(locked), .osc_req_o(osc_req), .enabled_o(enabled),
    .pin_debug_mode_o(pin_mode), .gpio_oe_allow_o(gpio_allow), .baud_count_o(baud),
    .prog_enable_o(prog_en), .erase_req_o(erase_req));
  one_wire_host one_wire_host_inst (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(host_ce), .link(link), .enable_i(enable),
    .hv_enable_i(hv_enable), .send_i(send), .data_i(data), .no_sync_next_i(no_sync),
    .finish_i(finish), .busy_o(busy), .ready_o(ready));
  one_wire_chk #(.SYNC_TIMEOUT(TMO)) chk (
    .clk_i(clk), .rst_n_i(rst_n), .dev_out_i(link.dev_out), .dev_oe_i(link.dev_oe),
    .host_out_i(link.host_out), .host_oe_i(link.host_oe), .hv_pulse_i(link.hv_pulse),
    .disable_store_i(link.disable_store), .line_i(link.line), .osc_req_i(osc_req),
    .enabled_i(enabled), .pin_debug_mode_i(pin_mode), .baud_count_i(baud));

  always #20 clk = ~clk;

  // oscillator answers a request after a fixed start-up delay
  always @(posedge clk) begin
    osc_cnt <= (osc_req === 1'b1) ? osc_cnt + 1 : 0;
    osc_ready <= (osc_req === 1'b1) && (osc_cnt >= 20);
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  task automatic wait_lvl(input logic v);
    int k;
    k = 0;
    while (line !== v && k < 4000) begin
      tick(1);
      k++;
    end
    check(16'(k < 4000), 16'h0001);
  endtask : wait_lvl

  // reads values settled by the previous edge, so bit centres sit one cycle late
  task automatic grab(input logic [7:0] b, input logic pre);
    logic [11:0] f;
    if (pre) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
    end
    wait_lvl(1'b0);
    tick(BIT / 2);
    for (int i = 0; i < 12; i++) begin
      f[i] = line;
      tick(BIT);
    end
    check(16'(f), 16'({2'b11, ^b, b, 1'b0}));
  endtask : grab

  task automatic host_op(input int op, input logic [7:0] d, input logic ns, output int c);
    c = 0;
    case (op)
      0: enable <= 1'b1;
      1: hv_enable <= 1'b1;
      2: begin
        send <= 1'b1;
        data <= d;
        no_sync <= ns;
      end
      default: finish <= 1'b1;
    endcase
    tick(1);
    {enable, hv_enable, send, finish} <= 4'h0;
    tick(1);
    check(16'(busy), 16'(op != 3));
    while (ready !== 1'(op != 3) && c < 6000) begin
      tick(1);
      c++;
    end
    check(16'(c < 6000), 16'h0001);
  endtask : host_op

  task automatic guard_chk();
    tick(80);
    check(16'(gpio_allow), 16'h0000);
    tick(30);
    check(16'(gpio_allow), 16'h0001);
  endtask : guard_chk

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    tick(20000);
    bad_count++;
    conclude();
  end

  initial begin
    tick(4);
    rst_n <= 1'b1;
    guard_chk();
    sys_reset <= 1'b1;
    tick(1);
    sys_reset <= 1'b0;
    guard_chk();
    fork
      host_op(0, 8'h00, 1'b0, n);
      grab(`SYNC_CHAR, 1'b1);
    join
    check(16'({enabled, osc_req, pin_mode, gpio_allow}), 16'h0001);
    host_op(3, 8'h00, 1'b0, n);
    fuse <= 1'b1;
    tick(6);
    check(16'({pin_mode, gpio_allow}), 16'h0002);
    fork
      host_op(0, 8'h00, 1'b0, n);
      grab(`SYNC_CHAR, 1'b1);
    join
    check(16'({enabled, osc_req}), 16'h0003);
    check(baud, `HOST_BIT_CYCLES << 3);
    // first byte carries no sync; a loop prefix spares the next one too
    for (int i = 0; i < 3; i++) begin
      fork
        host_op(2, dt[i], 1'(i == 0), n);
        grab(gb[i], 1'b0);
      join
      check(16'((n + BIT / 2) / BIT), 16'((i == 2) ? 24 : 12));
    end
    for (int i = 0; i < 3; i++) begin
      locked <= 1'(i < 2);
      key <= kt[i];
      key_strobe <= 1'b1;
      tick(1);
      key_strobe <= 1'b0;
      tick(1);
      // locked program ignored, locked erase honoured, unlocked program taken
      check(16'({prog_en, erase_req}), 16'(i));
    end
    host_op(3, 8'h00, 1'b0, n);
    tick(3);
    check(16'({enabled, osc_req, prog_en, pin_mode}), 16'h0001);
    // freeze the programmer after its low pulse so no sync ever follows
    enable <= 1'b1;
    tick(1);
    enable <= 1'b0;
    tick(10);
    host_ce <= 1'b0;
    wait_lvl(1'b1);
    n = 0;
    while (osc_req === 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check(16'(n >= TMO && n <= TMO + 8), 16'h0001);
    check(16'({line, enabled}), 16'h0002);
    rst_n <= 1'b0;
    host_ce <= 1'b1;
    fuse <= 1'b0;
    tick(4);
    rst_n <= 1'b1;
    tick(2);
    fork
      host_op(1, 8'h00, 1'b0, n);
      grab(`SYNC_CHAR, 1'b1);
    join
    check(16'({pin_mode, enabled, gpio_allow}), 16'h0006);
    host_op(3, 8'h00, 1'b0, n);
    tick(3);
    check(16'({enabled, osc_req, pin_mode}), 16'h0001);
    conclude();
  end
endmodule : tb_top
